/* File: rtl/pitc_cfg.svh */
`ifndef PITC_CFG_SVH
`define PITC_CFG_SVH

`define PITC_NPORTS      3
`define PITC_P1_OFS      8'h10
`define PITC_P2_OFS      8'h20
`define PITC_P3_OFS      8'h30
`define PITC_STORM_BIT   7
`define PITC_DSCP_BIT    6
`define PITC_DOT1P_BIT   5
`define PITC_PRIO_HI     4
`define PITC_PRIO_LO     3
`define PITC_TAGINS_BIT  2
`define PITC_CTRL_RST    8'h00
`define PITC_RESP_OKAY   2'h0
`define PITC_RESP_SLVERR 2'h2

`endif

/* File: rtl/pitc_pkg.sv */
package pitc_pkg;
	typedef logic [7:0]  pitc_ctrl_t;
	typedef logic [1:0]  pitc_prio_t;
	typedef logic [11:0] pitc_vid_t;
	typedef logic [1:0]  pitc_port_t;
endpackage : pitc_pkg

/* File: rtl/pitc_cfg_if.sv */
`timescale 1ns/1ps
interface pitc_cfg_if;
	pitc_pkg::pitc_ctrl_t ctrl [3];
	pitc_pkg::pitc_vid_t  vid  [3];
	modport regs (output ctrl, output vid);
	modport user (input ctrl, input vid);
endinterface : pitc_cfg_if

/* File: rtl/pitc_classify.sv */
`timescale 1ns/1ps
`include "pitc_cfg.svh"
module pitc_classify (
	input  wire logic                 mclk_i,
	input  wire logic                 resetn_i,
	pitc_cfg_if.user                  cfg,
	input  wire logic                 req_valid_i,
	input  wire pitc_pkg::pitc_port_t req_ingress_i,
	input  wire pitc_pkg::pitc_port_t req_egress_i,
	input  wire logic                 req_rx_tagged_i,
	input  wire logic                 req_dscp_hit_i,
	input  wire pitc_pkg::pitc_prio_t req_dscp_prio_i,
	input  wire logic                 req_dot1p_hit_i,
	input  wire pitc_pkg::pitc_prio_t req_dot1p_prio_i,
	output logic                      dec_valid_o,
	output pitc_pkg::pitc_prio_t      dec_queue_o,
	output logic                      dec_insert_tag_o,
	output pitc_pkg::pitc_vid_t       dec_vid_o
);
	logic                 in_ok;
	logic                 eg_ok;
	pitc_pkg::pitc_ctrl_t in_ctrl;
	pitc_pkg::pitc_ctrl_t eg_ctrl;
	logic                 dscp_ok;
	logic                 dot1p_ok;
	pitc_pkg::pitc_prio_t next_queue;

	// port code 3 names no port; such a request is dropped
	assign in_ok   = (req_ingress_i != 2'h3);
	assign eg_ok   = (req_egress_i != 2'h3);
	assign in_ctrl = in_ok ? cfg.ctrl[req_ingress_i] : `PITC_CTRL_RST;
	assign eg_ctrl = eg_ok ? cfg.ctrl[req_egress_i] : `PITC_CTRL_RST;
	assign dscp_ok  = in_ctrl[`PITC_DSCP_BIT] & req_dscp_hit_i; // R2
	assign dot1p_ok = in_ctrl[`PITC_DOT1P_BIT] & req_dot1p_hit_i; // R3

	always_comb begin
		if (dscp_ok | dot1p_ok) begin
			// any classifier result overrides the port queue
			next_queue = (dscp_ok ? req_dscp_prio_i : 2'h0)
				| (dot1p_ok ? req_dot1p_prio_i : 2'h0); // R5 R6
		end else begin
			next_queue = in_ctrl[`PITC_PRIO_HI:`PITC_PRIO_LO]; // R4
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dec_valid_o <= 1'b0;
		end else begin
			dec_valid_o <= req_valid_i & in_ok & eg_ok;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dec_queue_o      <= 2'h0;
			dec_insert_tag_o <= 1'b0;
			dec_vid_o        <= 12'h000;
		end else if (req_valid_i & in_ok & eg_ok) begin
			dec_queue_o      <= next_queue;
			// tagged frames never get a second tag
			dec_insert_tag_o <= eg_ctrl[`PITC_TAGINS_BIT] & ~req_rx_tagged_i; // R7 R8
			dec_vid_o        <= cfg.vid[req_ingress_i]; // R9
		end
	end
endmodule : pitc_classify

/* File: rtl/pitc_top.sv */
// Notes on behaviour
// (R1) control bit 7 set enables broadcast storm protection on that port's ingress
// (R2) bit 6 set enables DiffServ priority classification of received IPv4 frames
// (R3) bit 5 set enables 802.1p user priority classification of received frames
// (R4) bits 4-3 give the fallback queue 0..3 when no classifier decides
// (R5) DiffServ, 802.1p and port priority may all be enabled together
// (R6) with both classifiers hitting, their results are ORed and replace port priority
// (R7) bit 2 set adds a tag to untagged frames leaving that port
// (R8) frames received tagged get no extra tag on egress
// (R9) inserted tag carries the ingress port's default VID
// (R10) software sets up the VID configuration before relying on tag insertion
// (R11) three identical control registers at 0x10, 0x20 and 0x30
// (R12) all control fields reset to zero: features off, fallback queue 0
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pitc_cfg.svh"
module pitc_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic                 mclk_i,
	input  wire logic                 resetn_i,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
	input  wire logic                 s_axi_awvalid_i,
	output logic                      s_axi_awready_o,
	input  wire logic [31:0]          s_axi_wdata_i,
	input  wire logic [3:0]           s_axi_wstrb_i,
	input  wire logic                 s_axi_wvalid_i,
	output logic                      s_axi_wready_o,
	output logic [1:0]                s_axi_bresp_o,
	output logic                      s_axi_bvalid_o,
	input  wire logic                 s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
	input  wire logic                 s_axi_arvalid_i,
	output logic                      s_axi_arready_o,
	output logic [31:0]               s_axi_rdata_o,
	output logic [1:0]                s_axi_rresp_o,
	output logic                      s_axi_rvalid_o,
	input  wire logic                 s_axi_rready_i,
	input  wire pitc_pkg::pitc_vid_t  port_vid_i [3],
	input  wire logic                 req_valid_i,
	input  wire pitc_pkg::pitc_port_t req_ingress_i,
	input  wire pitc_pkg::pitc_port_t req_egress_i,
	input  wire logic                 req_rx_tagged_i,
	input  wire logic                 req_dscp_hit_i,
	input  wire pitc_pkg::pitc_prio_t req_dscp_prio_i,
	input  wire logic                 req_dot1p_hit_i,
	input  wire pitc_pkg::pitc_prio_t req_dot1p_prio_i,
	output logic                      dec_valid_o,
	output pitc_pkg::pitc_prio_t      dec_queue_o,
	output logic                      dec_insert_tag_o,
	output pitc_pkg::pitc_vid_t       dec_vid_o,
	output logic [2:0]                storm_protect_o
);
	localparam int NP = `PITC_NPORTS;

	pitc_pkg::pitc_ctrl_t ctrl [NP];
	logic                 aw_held;
	logic [ADDR_W-1:0]    aw_addr;
	logic                 w_held;
	logic [7:0]           w_data;
	logic                 w_lane0;
	logic                 aw_hs;
	logic                 w_hs;
	logic                 ar_hs;
	logic                 b_hs;
	logic                 r_hs;
	logic                 do_write;
	logic [NP-1:0]        wr_sel;
	logic [NP-1:0]        rd_sel;

	pitc_cfg_if cfg ();

	function automatic logic [NP-1:0] decode(input logic [ADDR_W-1:0] a);
		logic [NP-1:0] s;
		s    = '0;
		s[0] = (a == ADDR_W'(`PITC_P1_OFS));
		s[1] = (a == ADDR_W'(`PITC_P2_OFS));
		s[2] = (a == ADDR_W'(`PITC_P3_OFS));
		return s;
	endfunction : decode

	assign aw_hs    = s_axi_awvalid_i & s_axi_awready_o;
	assign w_hs     = s_axi_wvalid_i & s_axi_wready_o;
	assign ar_hs    = s_axi_arvalid_i & s_axi_arready_o;
	assign b_hs     = s_axi_bvalid_o & s_axi_bready_i;
	assign r_hs     = s_axi_rvalid_o & s_axi_rready_i;
	// commit one edge after both halves are held; simpler than a bypass path
	assign do_write = aw_held & w_held & ~s_axi_bvalid_o;
	assign wr_sel   = decode(aw_addr);
	assign rd_sel   = decode(s_axi_araddr_i);

	// write address channel
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (aw_hs) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_axi_awready_o <= 1'b0;
		end else if (aw_hs) begin
			s_axi_awready_o <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid_o) begin
			s_axi_awready_o <= 1'b1;
		end
	end

	// write data channel; only byte lane 0 carries register bits
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			w_held  <= 1'b0;
			w_data  <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (w_hs) begin
			w_held  <= 1'b1;
			w_data  <= s_axi_wdata_i[7:0];
			w_lane0 <= s_axi_wstrb_i[0];
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_axi_wready_o <= 1'b0;
		end else if (w_hs) begin
			s_axi_wready_o <= 1'b0;
		end else if (!w_held && !s_axi_bvalid_o) begin
			s_axi_wready_o <= 1'b1;
		end
	end

	// write response; unmapped addresses answer SLVERR and change nothing
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `PITC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (|wr_sel) ? `PITC_RESP_OKAY : `PITC_RESP_SLVERR;
		end else if (b_hs) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// one control register per port, same layout in each
	for (genvar g = 0; g < NP; g++) begin : g_port
		always_ff @(posedge mclk_i) begin
			if (!resetn_i) begin
				ctrl[g] <= `PITC_CTRL_RST; // R12
			end else if (do_write && wr_sel[g] && w_lane0) begin
				ctrl[g] <= w_data; // R11
			end
		end
		assign storm_protect_o[g] = ctrl[g][`PITC_STORM_BIT]; // R1
		assign cfg.ctrl[g]        = ctrl[g];
		// vid source must already be programmed for tag insertion to be useful
		assign cfg.vid[g]         = port_vid_i[g]; // R10
	end

	// read channel: data is captured at the address handshake
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_axi_arready_o <= 1'b0;
		end else if (ar_hs) begin
			s_axi_arready_o <= 1'b0;
		end else if (!s_axi_rvalid_o) begin
			s_axi_arready_o <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= `PITC_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= (|rd_sel) ? `PITC_RESP_OKAY : `PITC_RESP_SLVERR;
			// upper bits read as zero
			if (rd_sel[0]) begin
				s_axi_rdata_o <= {24'h00_0000, ctrl[0]}; // R11
			end else if (rd_sel[1]) begin
				s_axi_rdata_o <= {24'h00_0000, ctrl[1]};
			end else if (rd_sel[2]) begin
				s_axi_rdata_o <= {24'h00_0000, ctrl[2]};
			end else begin
				s_axi_rdata_o <= 32'h0000_0000;
			end
		end else if (r_hs) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	pitc_classify u_classify (
		.mclk_i           (mclk_i),
		.resetn_i         (resetn_i),
		.cfg              (cfg.user),
		.req_valid_i      (req_valid_i),
		.req_ingress_i    (req_ingress_i),
		.req_egress_i     (req_egress_i),
		.req_rx_tagged_i  (req_rx_tagged_i),
		.req_dscp_hit_i   (req_dscp_hit_i),
		.req_dscp_prio_i  (req_dscp_prio_i),
		.req_dot1p_hit_i  (req_dot1p_hit_i),
		.req_dot1p_prio_i (req_dot1p_prio_i),
		.dec_valid_o      (dec_valid_o),
		.dec_queue_o      (dec_queue_o),
		.dec_insert_tag_o (dec_insert_tag_o),
		.dec_vid_o        (dec_vid_o)
	);

	// checks below; helpers pick out requests with port 1 on one side
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	logic p1_req;
	logic p1_out;
	logic p1_dscp;
	logic p1_dot1p;
	// queue and vid follow ingress only, insertion follows egress only
	assign p1_req   = req_valid_i && req_ingress_i == 2'h0 && req_egress_i != 2'h3;
	assign p1_out   = req_valid_i && req_egress_i == 2'h0 && req_ingress_i != 2'h3;
	assign p1_dscp  = ctrl[0][`PITC_DSCP_BIT] && req_dscp_hit_i;
	assign p1_dot1p = ctrl[0][`PITC_DOT1P_BIT] && req_dot1p_hit_i;

	sequence wr_commit_s(int idx);
		do_write && wr_sel[idx] && w_lane0;
	endsequence

	sequence wr_pair_s;
		aw_hs && w_hs ##1 aw_held && w_held;
	endsequence

	storm_follows_a: assert property ( // R1
		wr_commit_s(0) |=> storm_protect_o[0] == $past(w_data[`PITC_STORM_BIT]))
		else $error("storm enable does not follow written bit");

	dscp_only_a: assert property ( // R2
		p1_req && p1_dscp && !p1_dot1p |=> dec_valid_o && dec_queue_o == $past(req_dscp_prio_i))
		else $error("dscp class not used as queue");

	dot1p_only_a: assert property ( // R3
		p1_req && p1_dot1p && !p1_dscp |=> dec_queue_o == $past(req_dot1p_prio_i))
		else $error("802.1p class not used as queue");

	fallback_a: assert property ( // R4
		p1_req && !p1_dscp && !p1_dot1p
			|=> dec_queue_o == $past(ctrl[0][`PITC_PRIO_HI:`PITC_PRIO_LO]))
		else $error("port fallback queue wrong");

	all_enabled_a: assert property ( // R5
		p1_req && ctrl[0][`PITC_DSCP_BIT] && ctrl[0][`PITC_DOT1P_BIT] && !req_dscp_hit_i
			&& !req_dot1p_hit_i |=> dec_valid_o && dec_queue_o == $past(ctrl[0][4:3]))
		else $error("co-enabled classifiers broke fallback");

	or_merge_a: assert property ( // R6
		p1_req && p1_dscp && p1_dot1p
			|=> dec_queue_o == ($past(req_dscp_prio_i) | $past(req_dot1p_prio_i)))
		else $error("classifier results not ORed");

	tag_insert_a: assert property ( // R7
		p1_out && ctrl[0][`PITC_TAGINS_BIT] && !req_rx_tagged_i |=> dec_insert_tag_o)
		else $error("untagged frame not tagged on egress");

	tag_disabled_a: assert property ( // R7
		p1_out && !ctrl[0][`PITC_TAGINS_BIT] |=> !dec_insert_tag_o)
		else $error("tag inserted while insertion off");

	no_double_a: assert property ( // R8
		req_valid_i && req_rx_tagged_i && req_ingress_i != 2'h3 && req_egress_i != 2'h3
			|=> !dec_insert_tag_o)
		else $error("tagged frame given a second tag");

	tag_vid_a: assert property ( // R9
		p1_req |=> dec_vid_o == $past(port_vid_i[0]))
		else $error("inserted vid not ingress port vid");

	write_bank_a: assert property ( // R11
		wr_commit_s(2) |=> ctrl[2] == $past(w_data) && ctrl[0] == $past(ctrl[0]))
		else $error("port 3 write landed wrong");

	read_back_a: assert property ( // R11
		ar_hs && rd_sel[1] |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h00_0000, $past(ctrl[1])}
			&& s_axi_rresp_o == `PITC_RESP_OKAY)
		else $error("port 2 read data wrong");

	write_resp_a: assert property ( // R11
		wr_pair_s |=> s_axi_bvalid_o ##0 s_axi_bvalid_o [*1] )
		else $error("write response not one edge after commit");

	unmapped_a: assert property ( // R11
		ar_hs && !(|rd_sel) |=> s_axi_rresp_o == `PITC_RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");

	rvalid_hold_a: assert property ( // R11
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped before taken");

	write_p1_a: assert property ( // R11
		wr_commit_s(0) |=> ctrl[0] == $past(w_data) && ctrl[1] == $past(ctrl[1])
			&& ctrl[2] == $past(ctrl[2]))
		else $error("port 1 write landed wrong");

	write_p2_a: assert property ( // R11
		wr_commit_s(1) |=> ctrl[1] == $past(w_data) && ctrl[2] == $past(ctrl[2]))
		else $error("port 2 write landed wrong");

	strobe_off_a: assert property ( // R11
		do_write && !w_lane0 |=> ctrl[0] == $past(ctrl[0]) && ctrl[1] == $past(ctrl[1])
			&& ctrl[2] == $past(ctrl[2]))
		else $error("write without lane 0 changed a register");

	unmapped_wr_a: assert property ( // R11
		do_write && !(|wr_sel) |=> s_axi_bvalid_o && s_axi_bresp_o == `PITC_RESP_SLVERR
			&& ctrl[0] == $past(ctrl[0]) && ctrl[1] == $past(ctrl[1]))
		else $error("unmapped write not refused");

	read_p1_a: assert property ( // R11
		ar_hs && rd_sel[0] |=> s_axi_rdata_o == {24'h00_0000, $past(ctrl[0])})
		else $error("port 1 read data wrong");

	read_p3_a: assert property ( // R11
		ar_hs && rd_sel[2] |=> s_axi_rdata_o == {24'h00_0000, $past(ctrl[2])})
		else $error("port 3 read data wrong");

	storm_p3_a: assert property ( // R1
		wr_commit_s(2) |=> storm_protect_o[2] == $past(w_data[`PITC_STORM_BIT]))
		else $error("port 3 storm enable does not follow written bit");

	dscp_p3_a: assert property ( // R2
		req_valid_i && req_ingress_i == 2'h2 && req_egress_i != 2'h3
			&& ctrl[2][`PITC_DSCP_BIT] && req_dscp_hit_i && !ctrl[2][`PITC_DOT1P_BIT]
			|=> dec_queue_o == $past(req_dscp_prio_i))
		else $error("port 3 dscp class not used as queue");

	tag_port3_a: assert property ( // R7
		req_valid_i && req_egress_i == 2'h2 && req_ingress_i != 2'h3
			&& ctrl[2][`PITC_TAGINS_BIT] && !req_rx_tagged_i |=> dec_insert_tag_o)
		else $error("untagged frame not tagged leaving port 3");

	vid_port3_a: assert property ( // R9
		req_valid_i && req_ingress_i == 2'h2 && req_egress_i != 2'h3
			|=> dec_vid_o == $past(port_vid_i[2]))
		else $error("vid not taken from port 3");

	reset_zero_a: assert property ( // R12
		$rose(resetn_i) |-> ctrl[0] == 8'h00 && ctrl[1] == 8'h00 && ctrl[2] == 8'h00
			&& storm_protect_o == 3'h0)
		else $error("control not zero after reset");
endmodule : pitc_top

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [1:0] ing, eg;
		logic       tg, dh;
		logic [1:0] dp;
		logic       ph;
		logic [1:0] pp, q;
		logic       ins;
	} pitc_row_t;
	logic                 mclk_i, resetn_i;
	logic [7:0]           awaddr, araddr;
	logic                 awvalid, wvalid, bready, arvalid, rready;
	logic [31:0]          wdata, rdata;
	logic [3:0]           wstrb;
	logic                 awready, wready, bvalid, arready, rvalid;
	logic [1:0]           bresp, rresp;
	pitc_pkg::pitc_vid_t  vid [3];
	logic                 req_valid, req_tg, req_dh, req_ph;
	pitc_pkg::pitc_port_t req_ing, req_eg;
	pitc_pkg::pitc_prio_t req_dp, req_pp, dq;
	logic                 dv, dins;
	pitc_pkg::pitc_vid_t  dvid;
	logic [2:0]           storm;
	logic [7:0]           ofs [3];
	pitc_row_t            rows [8];
	pitc_row_t            r;
	int                   num_errors, checked;

	pitc_top #(.ADDR_W(8)) dut (
		.mclk_i(mclk_i), .resetn_i(resetn_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .port_vid_i(vid),
		.req_valid_i(req_valid), .req_ingress_i(req_ing), .req_egress_i(req_eg),
		.req_rx_tagged_i(req_tg), .req_dscp_hit_i(req_dh), .req_dscp_prio_i(req_dp),
		.req_dot1p_hit_i(req_ph), .req_dot1p_prio_i(req_pp), .dec_valid_o(dv),
		.dec_queue_o(dq), .dec_insert_tag_o(dins), .dec_vid_o(dvid),
		.storm_protect_o(storm)
	);

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// master releases each channel only at the edge where it is taken
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
			input logic [1:0] er);
		logic aw = 1'b0, w = 1'b0, b = 1'b0;
		@(posedge mclk_i);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {24'h00_0000, d};
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(posedge mclk_i);
			if (!aw && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				b = 1'b1;
				bready <= 1'b0;
				chk("bresp", 32'(bresp), 32'(er));
			end
		end
		if (!b)
			chk("bvalid", 32'(b), 32'h0000_0001);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
			input logic late = 1'b0);
		logic ar = 1'b0, rd = 1'b0;
		@(posedge mclk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= !late;
		for (int n = 0; n < 40 && !rd; n++) begin
			@(posedge mclk_i);
			if (!ar && arready) begin
				ar = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid && rready) begin
				rd = 1'b1;
				rready <= 1'b0;
				chk("rdata", rdata, ed);
				chk("rresp", 32'(rresp), 32'(er));
			end else if (rvalid) begin
				// late master: the answer has to stand until taken
				rready <= 1'b1;
			end
		end
		if (!rd)
			chk("rvalid", 32'(rd), 32'h0000_0001);
	endtask : axi_rd

	task automatic drive(input pitc_row_t x, input logic v);
		@(posedge mclk_i);
		req_valid <= v;
		req_ing   <= x.ing;
		req_eg    <= x.eg;
		req_tg    <= x.tg;
		req_dh    <= x.dh;
		req_dp    <= x.dp;
		req_ph    <= x.ph;
		req_pp    <= x.pp;
	endtask : drive

	task automatic chk_dec(input pitc_row_t x);
		chk("dec_valid", 32'(dv), 32'h0000_0001);
		chk("dec_queue", 32'(dq), 32'(x.q));
		chk("dec_insert", 32'(dins), 32'(x.ins));
		chk("dec_vid", 32'(dvid), 32'(vid[x.ing]));
	endtask : chk_dec

	// the whole run is some 130 cycles
	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		give_verdict();
	end

	initial begin
		{resetn_i, awvalid, wvalid, bready, arvalid, rready, req_valid} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{req_tg, req_dh, req_ph, req_ing, req_eg, req_dp, req_pp} = '0;
		vid = '{12'h0a1, 12'h5b2, 12'hfc3};
		ofs = '{8'h10, 8'h20, 8'h30};
		// p1: dscp+dot1p, fallback 2, insert; p2: fallback 3 only; p3: storm, dscp, insert
		rows = '{'{0, 0, 0, 1, 1, 1, 2, 3, 1}, '{0, 1, 1, 1, 2, 0, 0, 2, 0},
			'{0, 2, 0, 0, 0, 1, 1, 1, 1}, '{0, 0, 1, 0, 0, 0, 0, 2, 0},
			'{1, 1, 0, 1, 1, 1, 2, 3, 0}, '{2, 0, 0, 1, 1, 1, 2, 1, 1},
			'{2, 2, 1, 0, 0, 0, 0, 0, 0}, '{0, 1, 0, 1, 3, 1, 1, 3, 0}};
		repeat (16) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		chk("storm", 32'(storm), 32'h0000_0000);
		chk("dec_valid", 32'(dv), 32'h0000_0000);
		for (int k = 0; k < 3; k++) begin
			axi_rd(ofs[k], 32'h0000_0000, 2'h0);
			axi_wr(ofs[k], 8'hff, 4'h1, 2'h0);
			axi_rd(ofs[k], 32'h0000_00ff, 2'h0);
			chk("storm", 32'(storm), 32'((2 << k) - 1));
		end
		axi_wr(8'h14, 8'h55, 4'h1, 2'h2);
		axi_rd(8'h14, 32'h0000_0000, 2'h2);
		axi_wr(8'h10, 8'h00, 4'h0, 2'h0);
		axi_rd(8'h10, 32'h0000_00ff, 2'h0, 1'b1);
		axi_wr(ofs[0], 8'h74, 4'h1, 2'h0);
		axi_wr(ofs[1], 8'h18, 4'h1, 2'h0);
		axi_wr(ofs[2], 8'hc4, 4'h1, 2'h0);
		chk("storm", 32'(storm), 32'h0000_0004);
		// back-to-back requests, one per cycle
		for (int i = 0; i < 8; i++) begin
			drive(rows[i], 1'b1);
			#1;
			if (i > 0)
				chk_dec(rows[i - 1]);
		end
		drive(rows[7], 1'b0);
		#1;
		chk_dec(rows[7]);
		for (int c = 0; c < 2; c++) begin
			// a taken request here would move the queue away from rows[7]
			r = rows[3];
			if (c == 0)
				r.ing = 2'h3;
			else
				r.eg = 2'h3;
			drive(r, 1'b1);
			drive(r, 1'b0);
			#1;
			chk("dropped", 32'(dv), 32'h0000_0000);
			chk("held_queue", 32'(dq), 32'(rows[7].q));
			chk("held_vid", 32'(dvid), 32'(vid[rows[7].ing]));
		end
		// disabled classifiers on port 2 leave only the fallback field
		for (int p = 0; p < 4; p++) begin
			axi_wr(ofs[1], 8'(p << 3), 4'h1, 2'h0);
			r = rows[4];
			r.q = 2'(p);
			drive(r, 1'b1);
			drive(r, 1'b0);
			#1;
			chk_dec(r);
		end
		// port 1 cleared: hits ignored, fallback queue 0, no tag
		axi_wr(ofs[0], 8'h00, 4'h1, 2'h0);
		r     = rows[0];
		r.q   = 2'h0;
		r.ins = 1'b0;
		drive(r, 1'b1);
		drive(r, 1'b0);
		#1;
		chk_dec(r);
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		resetn_i <= 1'b1;
		for (int k = 0; k < 3; k++)
			axi_rd(ofs[k], 32'h0000_0000, 2'h0);
		chk("storm", 32'(storm), 32'h0000_0000);
		give_verdict();
	end
endmodule : tb_top
